//--- canf_top.sv
// Design: acceptance filtering and bit timing of a CAN receiver, with Avalon-MM registers
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Filter each assembled message, load only matches
// - Mask bit zero accepts identifier bit
// - Mask bit one demands equality, all bits
// - Legacy: filters 0-1 high, 2-5 low
// - Enhanced: sixteen filters, each individually enabled
// - Filter fifteen may serve as mask
// - Four-bit association field selects target buffer
// - Per-filter select bits choose the mask
// - Legacy low buffer hit code equals filter
// - Codes 000/001 low only with rollover
// - High buffer reports 110/111 for filters
// - Enhanced five-bit hit holds filter number
// - Lowest-numbered matching filter wins
// - Mask and filter writes only in configuration
// - Quantum is two times prescaler+1 clocks
// - Bit is sync, prop, phase one, two
// - Nominal bit time spans 8 to 25
// - Edge at least every six bit times
// - DPLL syncs to edges, times transmission
// - Sync segment lasts exactly one quantum
// - Propagation segment one to eight quanta
// - Jump width one to four quanta
module canf_top
  import canf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CAN_RX,
  input wire logic MSG_VALID,
  input wire canf_msg_s MSG_IN,
  output logic LOAD_STB,
  output canf_load_s LOAD_OUT,
  output logic SAMPLE_STB,
  output logic RX_BIT,
  output logic BIT_START
);

  // Software-visible state
  logic [4:0] ctrl_reg;                  // Config mode, mode, rollover, filter 15 as mask
  logic [16:0] brg_reg;                  // Prescaler and segment lengths
  logic [15:0] fen_reg;                  // Per-filter enable
  logic [3:0] assoc_reg [NUM_FILT];      // Filter to buffer association nibbles
  logic [1:0] msel_reg [NUM_FILT];       // Filter to mask select pairs
  canf_msg_s mask_reg [2];               // Acceptance masks zero and one
  canf_msg_s filt_reg [NUM_FILT];        // Acceptance filters
  logic [7:0] full_reg;                  // Buffer occupied flags, set on load
  logic [4:0] hit_reg [NUM_BUF];         // Per-buffer filter hit code
  logic run6_reg;                        // Sticky: six equal bits seen inside a frame
  logic idle_reg;                        // Bus idle: long recessive run seen, next fall is a hard sync

  // Bus slave state
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;

  // Decoded control fields
  wire cfg_mode = ctrl_reg[CTRL_CFG_BIT];
  wire [1:0] mode = ctrl_reg[CTRL_MODE_LSB +: 2];
  wire legacy = (mode == MODE_LEGACY);
  wire rollover_enable = ctrl_reg[CTRL_ROLL_BIT];
  wire f15_is_mask = ctrl_reg[CTRL_F15M_BIT];
  wire [5:0] rate_prescaler = brg_reg[BRG_PRESC_LSB +: 6];
  wire [2:0] prop_fld = brg_reg[BRG_PROP_LSB +: 3];
  wire [2:0] ph1_fld = brg_reg[BRG_PH1_LSB +: 3];
  wire [2:0] ph2_fld = brg_reg[BRG_PH2_LSB +: 3];
  wire [1:0] jump_fld = brg_reg[BRG_JUMP_LSB +: 2];

  // Write strobes: a write lands only at the edge where waitrequest is seen low
  wire wr_take = AVS_WRITE && !wait_reg;
  wire sel_filt = (AVS_ADDRESS[7:6] == OFS_FILT_TOP);
  wire [3:0] filt_idx = AVS_ADDRESS[5:2];
  wire wr_ctrl = wr_take && (AVS_ADDRESS == OFS_CTRL);
  wire wr_brg = wr_take && (AVS_ADDRESS == OFS_BRG);
  wire wr_fen = wr_take && (AVS_ADDRESS == OFS_FEN);
  wire wr_alo = wr_take && (AVS_ADDRESS == OFS_ASSOC_LO);
  wire wr_ahi = wr_take && (AVS_ADDRESS == OFS_ASSOC_HI);
  wire wr_msel = wr_take && (AVS_ADDRESS == OFS_MSEL);
  wire wr_stat = wr_take && (AVS_ADDRESS == OFS_STATUS);
  wire wr_mask0 = wr_take && cfg_mode && (AVS_ADDRESS == OFS_MASK0);
  wire wr_mask1 = wr_take && cfg_mode && (AVS_ADDRESS == OFS_MASK1);
  wire wr_filt = wr_take && cfg_mode && sel_filt;

  // Bit timing arithmetic, in quanta except tq_div and bit_cyc, which count clocks
  wire [7:0] tq_div = {1'b0, rate_prescaler, 1'b0} + 8'h02;
  wire [3:0] prop_len = {1'b0, prop_fld} + 4'h1;
  wire [3:0] jump_len = {2'b00, jump_fld} + 4'h1;
  wire [4:0] nbt_tq = 5'(SYNC_SEG_TQ) + {1'b0, prop_len} + {2'b00, ph1_fld} + {2'b00, ph2_fld} + 5'h02;
  // Widen both factors first so the product is not cut to eight bits
  wire [12:0] bit_cyc = 13'(tq_div) * 13'(nbt_tq);
  // Reported only: keeping the timing legal is software's job
  wire timing_bad = (nbt_tq < 5'(NBT_MIN_TQ)) || (nbt_tq > 5'(NBT_MAX_TQ))
                    || ({1'b0, ph2_fld} + 4'h1 < 4'(IPT_TQ))
                    || (bit_cyc < 13'(MIN_BIT_CYC));

  // Readback mux, unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (AVS_ADDRESS == OFS_CTRL)
      rd_mux = {27'h0, ctrl_reg};
    else if (AVS_ADDRESS == OFS_BRG)
      rd_mux = {15'h0, brg_reg};
    else if (AVS_ADDRESS == OFS_FEN)
      rd_mux = {16'h0, fen_reg};
    else if (AVS_ADDRESS == OFS_ASSOC_LO)
      rd_mux = {assoc_reg[7], assoc_reg[6], assoc_reg[5], assoc_reg[4],
                assoc_reg[3], assoc_reg[2], assoc_reg[1], assoc_reg[0]};
    else if (AVS_ADDRESS == OFS_ASSOC_HI)
      rd_mux = {assoc_reg[15], assoc_reg[14], assoc_reg[13], assoc_reg[12],
                assoc_reg[11], assoc_reg[10], assoc_reg[9], assoc_reg[8]};
    else if (AVS_ADDRESS == OFS_MSEL)
      for (int i = 0; i < NUM_FILT; i++)
        rd_mux[2*i +: 2] = msel_reg[i];
    else if (AVS_ADDRESS == OFS_STATUS)
      rd_mux = {21'h0, timing_bad, run6_reg, idle_reg, full_reg};
    else if (AVS_ADDRESS == OFS_HIT_LO)
      for (int i = 0; i < 4; i++)
        rd_mux[8*i +: 5] = hit_reg[i];
    else if (AVS_ADDRESS == OFS_HIT_HI)
      for (int i = 0; i < 4; i++)
        rd_mux[8*i +: 5] = hit_reg[i+4];
    else if (AVS_ADDRESS == OFS_MASK0)
      rd_mux = {2'b00, mask_reg[0]};
    else if (AVS_ADDRESS == OFS_MASK1)
      rd_mux = {2'b00, mask_reg[1]};
    else if (sel_filt)
      rd_mux = {2'b00, filt_reg[filt_idx]};
  end

  // Avalon handshake: one wait cycle, then a single low cycle that completes the access
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else if ((AVS_READ || AVS_WRITE) && wait_reg)
    begin
      wait_reg <= 1'b0;
      rdata_reg <= AVS_READ ? rd_mux : 32'h0000_0000;
    end
    else
      wait_reg <= 1'b1;
  end
  assign AVS_WAITREQUEST = wait_reg;
  assign AVS_READDATA = rdata_reg;

  // Control, timing, enable, association and mask select registers
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_reg <= CTRL_RST;
      brg_reg <= BRG_RST;
      fen_reg <= 16'h0000;
      for (int i = 0; i < NUM_FILT; i++)
      begin
        assoc_reg[i] <= 4'h0;
        msel_reg[i] <= MSEL_MASK0;
      end
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= AVS_WRITEDATA[4:0];
      if (wr_brg)
        brg_reg <= AVS_WRITEDATA[16:0];
      if (wr_fen)
        fen_reg <= AVS_WRITEDATA[15:0];
      for (int i = 0; i < 8; i++)
      begin
        if (wr_alo)
          assoc_reg[i] <= AVS_WRITEDATA[4*i +: 4];
        if (wr_ahi)
          assoc_reg[i+8] <= AVS_WRITEDATA[4*i +: 4];
      end
      for (int i = 0; i < NUM_FILT; i++)
        if (wr_msel)
          msel_reg[i] <= AVS_WRITEDATA[2*i +: 2];
    end
  end

  // Mask and filter storage, locked outside configuration mode
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mask_reg[0] <= '0;
      mask_reg[1] <= '0;
      for (int i = 0; i < NUM_FILT; i++)
        filt_reg[i] <= '0;
    end
    else
    begin
      if (wr_mask0)
        mask_reg[0] <= AVS_WRITEDATA[29:0];
      if (wr_mask1)
        mask_reg[1] <= AVS_WRITEDATA[29:0];
      if (wr_filt)
        filt_reg[filt_idx] <= AVS_WRITEDATA[29:0];
    end
  end

  // Per-filter hit vector; legacy fixes the pairing, enhanced follows enable and select bits
  logic [15:0] hit_vec;
  for (genvar g = 0; g < NUM_FILT; g++)
  begin : g_filt
    canf_msg_s eff_mask;
    logic en;
    always_comb
    begin
      if (legacy)
      begin
        eff_mask = (g < 2) ? mask_reg[0] : mask_reg[1];
        en = (g < 6);
      end
      else
      begin
        if (msel_reg[g] == MSEL_MASK0)
          eff_mask = mask_reg[0];
        else if (msel_reg[g] == MSEL_MASK1)
          eff_mask = mask_reg[1];
        else if (msel_reg[g] == MSEL_F15)
          eff_mask = filt_reg[15];
        else
          eff_mask = '0;                                        // No mask: every identifier bit accepted
        en = fen_reg[g] && !((g == 15) && f15_is_mask);
      end
    end
    assign hit_vec[g] = en && canf_id_match(filt_reg[g], eff_mask, MSG_IN);
  end

  // Lowest matching filter per group
  wire [4:0] hi_first = canf_first(hit_vec & 16'h0003);
  wire [4:0] lo_first = canf_first(hit_vec & 16'h003c);
  wire [4:0] en_first = canf_first(hit_vec);
  wire [3:0] en_dest = assoc_reg[en_first[3:0]];

  // Acceptance decision; a full target buffer or no match means nothing changes
  logic go;
  canf_load_s load_next;
  always_comb
  begin
    go = 1'b0;
    load_next = '0;
    if (legacy)
    begin
      if (hi_first[4] && !full_reg[HIGH_BUF[2:0]])
      begin
        go = 1'b1;
        load_next = {HIGH_BUF, 4'b0011, hi_first[0]};
      end
      else if (hi_first[4] && rollover_enable && !full_reg[LOW_BUF[2:0]])
      begin
        go = 1'b1;
        load_next = {LOW_BUF, 1'b0, hi_first[3:0]};
      end
      else if (lo_first[4] && !full_reg[LOW_BUF[2:0]])
      begin
        go = 1'b1;
        load_next = {LOW_BUF, 1'b0, lo_first[3:0]};
      end
    end
    else if (en_first[4] && (en_dest < 4'(NUM_BUF)) && !full_reg[en_dest[2:0]])
    begin
      go = 1'b1;
      load_next = {en_dest, 1'b0, en_first[3:0]};
    end
  end

  // Latch the decision one edge after the message; the next message may follow at once
  wire [7:0] full_clr = wr_stat ? AVS_WRITEDATA[7:0] : 8'h00;
  wire [7:0] full_set = (MSG_VALID && go) ? 8'(8'h01 << load_next.buf_idx[2:0]) : 8'h00;
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      LOAD_STB <= 1'b0;
      LOAD_OUT <= '0;
      full_reg <= 8'h00;
      for (int i = 0; i < NUM_BUF; i++)
        hit_reg[i] <= 5'h00;
    end
    else
    begin
      LOAD_STB <= MSG_VALID && go;
      if (MSG_VALID && go)
      begin
        LOAD_OUT <= load_next;
        hit_reg[load_next.buf_idx[2:0]] <= load_next.hit;
      end
      // A load in the same cycle as a software clear keeps the buffer marked full
      full_reg <= (full_reg & ~full_clr) | full_set;
    end
  end

  // Quantum divider: a one-cycle tick every 2*(prescaler+1) clocks, restarted by synchronisation
  logic [7:0] tq_cnt_reg;
  logic restart;
  wire tq_en = (tq_cnt_reg == tq_div - 8'h01);
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      tq_cnt_reg <= 8'h00;
    else if (restart || tq_en)
      tq_cnt_reg <= 8'h00;
    else
      tq_cnt_reg <= tq_cnt_reg + 8'h01;
  end

  // DPLL state
  canf_seg_e seg_reg;
  logic [3:0] seg_cnt_reg;   // Quanta spent in current segment
  logic [4:0] bit_tq_reg;    // Quanta since start of bit
  logic [3:0] ext_reg;       // Phase one lengthening
  logic [3:0] short_reg;     // Phase two shortening
  logic sync_done_reg;       // One synchronisation per bit only
  logic rx_prev_reg;
  logic last_sample_reg;
  logic [3:0] run_reg;       // Equal consecutive samples

  wire [3:0] ph1_len = {1'b0, ph1_fld} + 4'h1 + ext_reg;
  wire [3:0] ph2_len = {1'b0, ph2_fld} + 4'h1 - short_reg;
  wire [3:0] seg_len = (seg_reg == SEG_SYNC) ? 4'(SYNC_SEG_TQ) :
                       (seg_reg == SEG_PROP) ? prop_len :
                       (seg_reg == SEG_PH1) ? ph1_len : ph2_len;
  wire seg_end = tq_en && (seg_cnt_reg == seg_len - 4'h1);
  // Only recessive-to-dominant edges after a recessive sample carry clock information
  wire fall = rx_prev_reg && !CAN_RX;
  wire hard_sync = fall && idle_reg;
  wire resync_ok = fall && !idle_reg && !sync_done_reg && last_sample_reg;
  wire in_early = (seg_reg == SEG_PROP) || (seg_reg == SEG_PH1);
  wire [3:0] neg_err = ph2_len - seg_cnt_reg;
  wire small_err = in_early ? ({1'b0, bit_tq_reg[3:0]} <= {1'b0, jump_len}) && (bit_tq_reg < 5'h10)
                            : (neg_err <= jump_len);
  assign restart = hard_sync || (resync_ok && (seg_reg != SEG_SYNC) && small_err);
  wire sample_now = seg_end && (seg_reg == SEG_PH1);

  // Segment sequencer; restart behaves as a hard synchronisation and reopens the sync segment
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      seg_reg <= SEG_SYNC;
      seg_cnt_reg <= 4'h0;
      bit_tq_reg <= 5'h00;
      ext_reg <= 4'h0;
      short_reg <= 4'h0;
      sync_done_reg <= 1'b0;
      BIT_START <= 1'b0;
    end
    else if (restart)
    begin
      seg_reg <= SEG_SYNC;
      seg_cnt_reg <= 4'h0;
      bit_tq_reg <= 5'h00;
      ext_reg <= 4'h0;
      short_reg <= 4'h0;
      sync_done_reg <= 1'b1;
      BIT_START <= 1'b1;
    end
    else
    begin
      BIT_START <= seg_end && (seg_reg == SEG_PH2);
      if (resync_ok)
      begin
        sync_done_reg <= 1'b1;
        // Large errors move the sample point by the jump width only
        if (in_early)
          ext_reg <= jump_len;
        else if (seg_reg == SEG_PH2)
          short_reg <= jump_len;
      end
      if (tq_en)
        bit_tq_reg <= bit_tq_reg + 5'h01;
      if (seg_end)
      begin
        seg_cnt_reg <= 4'h0;
        case (seg_reg)
          SEG_SYNC: seg_reg <= SEG_PROP;
          SEG_PROP: seg_reg <= SEG_PH1;
          SEG_PH1: seg_reg <= SEG_PH2;
          default:
          begin
            seg_reg <= SEG_SYNC;
            bit_tq_reg <= 5'h00;
            ext_reg <= 4'h0;
            short_reg <= 4'h0;
            sync_done_reg <= 1'b0;
          end
        endcase
      end
      else if (tq_en)
        seg_cnt_reg <= seg_cnt_reg + 4'h1;
    end
  end

  // Sampling, idle detection and run-length watch on the received level
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rx_prev_reg <= 1'b1;
      last_sample_reg <= 1'b1;
      idle_reg <= 1'b1;
      run_reg <= 4'h0;
      run6_reg <= 1'b0;
      SAMPLE_STB <= 1'b0;
      RX_BIT <= 1'b1;
    end
    else
    begin
      rx_prev_reg <= CAN_RX;
      SAMPLE_STB <= sample_now;
      if (sample_now)
      begin
        RX_BIT <= CAN_RX;
        last_sample_reg <= CAN_RX;
        run_reg <= (CAN_RX == last_sample_reg && run_reg != 4'hf) ? run_reg + 4'h1 : 4'h1;
      end
      if (hard_sync)
        idle_reg <= 1'b0;
      else if (sample_now && CAN_RX && last_sample_reg && run_reg >= 4'(IDLE_RUN - 1))
        idle_reg <= 1'b1;
      // Flag set wins over a software clear in the same cycle
      if (sample_now && !idle_reg && CAN_RX == last_sample_reg && run_reg == 4'(STUFF_RUN - 1))
        run6_reg <= 1'b1;
      else if (wr_stat && AVS_WRITEDATA[STAT_RUN6_BIT])
        run6_reg <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  logic [7:0] gap_reg;       // Clocks since last quantum tick or restart
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      gap_reg <= 8'h00;
    else
      gap_reg <= (tq_en || restart) ? 8'h00 : gap_reg + 8'h01;
  end

  sequence s_msg_match;
    MSG_VALID && go;
  endsequence
  sequence s_loaded;
    LOAD_STB && LOAD_OUT == $past(load_next);
  endsequence

  a_load_on_match: assert property (s_msg_match |=> s_loaded)
    else $error("Matched message not loaded");
  a_no_match_drop: assert property (MSG_VALID && !go |=> !LOAD_STB && $stable(full_reg) || $past(wr_stat))
    else $error("Unmatched message changed buffers");
  a_mask_zero_accept: assert property (MSG_VALID && legacy && mask_reg[0].id == '0
      && filt_reg[0].ext == MSG_IN.ext && !full_reg[0] |=> LOAD_STB && LOAD_OUT.buf_idx == HIGH_BUF)
    else $error("Cleared mask did not accept");
  a_mask_one_reject: assert property (MSG_VALID && legacy && &mask_reg[0].id && filt_reg[0].id != MSG_IN.id
      && filt_reg[1].id != MSG_IN.id |=> !(LOAD_STB && LOAD_OUT.hit[4:1] == 4'b0011))
    else $error("Masked mismatch accepted");
  a_high_hit_code: assert property (LOAD_STB && LOAD_OUT.buf_idx == HIGH_BUF && $past(legacy)
      |-> LOAD_OUT.hit[4:1] == 4'b0011)
    else $error("High buffer hit code wrong");
  a_rollover_code: assert property (LOAD_STB && LOAD_OUT.buf_idx == LOW_BUF && LOAD_OUT.hit < 5'h02
      && $past(legacy) |-> $past(rollover_enable))
    else $error("Rollover code without rollover");
  a_lowest_wins: assert property (MSG_VALID && !legacy && hit_vec[0] && go |=> LOAD_OUT.hit == 5'h00)
    else $error("Lower filter lost priority");
  a_cfg_lock: assert property (wr_take && sel_filt && !cfg_mode
      |=> filt_reg[$past(filt_idx)] == $past(filt_reg[filt_idx]))
    else $error("Filter written outside configuration");
  a_tq_period: assert property (tq_en && !restart && $stable(brg_reg)
      |-> gap_reg == {1'b0, rate_prescaler, 1'b1})
    else $error("Quantum period wrong");
  a_sync_one_tq: assert property (seg_reg == SEG_SYNC && tq_en && !restart |=> seg_reg == SEG_PROP)
    else $error("Sync segment not one quantum");

endmodule : canf_top

`default_nettype wire

//--- canf_pkg.sv
// Package: register map, field layout, reset values, types and helpers of the CAN filter and bit timing block
package canf_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BRG = 8'h04;
  localparam logic [7:0] OFS_FEN = 8'h08;
  localparam logic [7:0] OFS_ASSOC_LO = 8'h0c;
  localparam logic [7:0] OFS_ASSOC_HI = 8'h10;
  localparam logic [7:0] OFS_MSEL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_HIT_LO = 8'h1c;
  localparam logic [7:0] OFS_HIT_HI = 8'h20;
  localparam logic [7:0] OFS_MASK0 = 8'h24;
  localparam logic [7:0] OFS_MASK1 = 8'h28;
  localparam logic [1:0] OFS_FILT_TOP = 2'h1;  // Filters 0..15 sit at 0x40 + 4*n

  // Control register fields
  localparam int CTRL_CFG_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_ROLL_BIT = 3;
  localparam int CTRL_F15M_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h01;     // Leaves reset in configuration mode

  // Bit rate configuration fields
  localparam int BRG_PRESC_LSB = 0;
  localparam int BRG_PROP_LSB = 6;
  localparam int BRG_PH1_LSB = 9;
  localparam int BRG_PH2_LSB = 12;
  localparam int BRG_JUMP_LSB = 15;
  localparam logic [16:0] BRG_RST = 17'h01440; // 1+2+3+2 = 8 TQ, prescaler 0

  // Status fields
  localparam int STAT_IDLE_BIT = 8;
  localparam int STAT_RUN6_BIT = 9;
  localparam int STAT_TBAD_BIT = 10;

  // Modes and buffers
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam int NUM_FILT = 16;
  localparam int NUM_BUF = 8;
  localparam logic [3:0] HIGH_BUF = 4'h0;
  localparam logic [3:0] LOW_BUF = 4'h1;
  localparam logic [1:0] MSEL_MASK0 = 2'h0;
  localparam logic [1:0] MSEL_MASK1 = 2'h1;
  localparam logic [1:0] MSEL_F15 = 2'h2;

  // Bit timing limits, in time quanta and bit times
  localparam int SYNC_SEG_TQ = 1;
  localparam int NBT_MIN_TQ = 8;
  localparam int NBT_MAX_TQ = 25;
  localparam int IPT_TQ = 2;
  localparam int STUFF_RUN = 6;
  localparam int IDLE_RUN = 11;

  // Shortest bit time, turned into system clock cycles (rounded up)
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_BIT_NS = 1000;
  localparam int MIN_BIT_CYC = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Identifier as held in the assembly buffer and in every filter or mask
  typedef struct packed {
    logic ext;
    logic [28:0] id;
  } canf_msg_s;

  // Result of one acceptance decision
  typedef struct packed {
    logic [3:0] buf_idx;
    logic [4:0] hit;
  } canf_load_s;

  // Bit segments, Gray coded along sync-prop-ph1-ph2
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1 = 2'b11,
    SEG_PH2 = 2'b10
  } canf_seg_e;

  // Masked compare: a zero mask bit accepts, a one demands equality; frame type always compared
  function automatic logic canf_id_match(input canf_msg_s filt, input canf_msg_s mask, input canf_msg_s msg);
    return (filt.ext == msg.ext) && (&(~mask.id | ~(filt.id ^ msg.id)));
  endfunction : canf_id_match

  // Lowest set bit of a hit vector as {found, index}
  function automatic logic [4:0] canf_first(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : canf_first

endpackage : canf_pkg

//--- canf_node_model.sv
// Far-side CAN node: sends a short bit pattern, bus recessive otherwise
`timescale 1ns/100ps
`default_nettype none
module canf_node_model #(parameter int BIT_CYC = 112)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  output logic rx
);
  logic [11:0] pat_reg; // Bits left, msb first; a released bus reads recessive
  int cnt_reg; // Clocks left in the current bit
  assign rx = pat_reg[11];
  // Runs stay under six until the closing recessive run, which the receiver flags and then reads as idle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      pat_reg <= 12'hfff;
    else if (go)
      pat_reg <= 12'h4bf;
    else if (cnt_reg == 0)
      pat_reg <= {pat_reg[10:0], 1'b1};
  // Bit length counter, restarted with each pattern
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      cnt_reg <= 0;
    else
      cnt_reg <= (go || cnt_reg == 0) ? BIT_CYC - 1 : cnt_reg - 1;
endmodule : canf_node_model
`default_nettype wire

//--- can_acceptance_filter_bit_timing_test.sv
// Testbench: filtering through registers and message port, bit timing from a bus node
`timescale 1ns/100ps
`default_nettype none
module can_acceptance_filter_bit_timing_test
  import canf_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wq, rx, go = 1'b0, mv = 1'b0, lstb, sstb, rxb, bst;
  canf_msg_s mi = '0;
  canf_load_s lout;
  int errors = 0;
  int compares = 0;
  always #5 clk = ~clk;
  canf_top u_dut (.CLK_SYS(clk), .ARST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .CAN_RX(rx), .MSG_VALID(mv),
    .MSG_IN(mi), .LOAD_STB(lstb), .LOAD_OUT(lout), .SAMPLE_STB(sstb), .RX_BIT(rxb), .BIT_START(bst));
  canf_node_model #(.BIT_CYC(112)) u_node (.clk(clk), .arst_n(rst_n), .go(go), .rx(rx));
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // Avalon master: hold until waitrequest low, then release and idle one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  // One assembled message; the load pulse stands in the cycle after it
  task automatic msg(input logic [28:0] id, input logic ld, input canf_load_s e, input string m);
    mv <= 1'b1;
    mi <= {1'b0, id};
    @(posedge clk);
    mv <= 1'b0;
    #1;
    chk(lstb === ld && (!ld || lout === e), m);
    @(posedge clk);
  endtask : msg
  task automatic t_reset;
    logic [31:0] q;
    bus(0, OFS_CTRL, 0, q);
    chk(q === 32'h1, "ctrl reset");
    bus(0, OFS_BRG, 0, q);
    chk(q === {15'h0, BRG_RST}, "brg reset");
    bus(0, 8'hfc, 0, q);
    chk(q === 32'h0, "unmapped read");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_timing;
    logic [31:0] q;
    int n, k;
    bus(1, OFS_BRG, 32'h1446, q);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (!(sstb === 1'b1 && rxb === 1'b0) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 3000, "hard sync sample");
    n = 0;
    k = 0;
    // No falling edge in the recessive bit, so its length is nominal: 8 TQ of 14 clocks
    do
    begin
      @(posedge clk);
      n++;
      k += (bst === 1'b1);
    end while (sstb !== 1'b1 && n < 300);
    chk(n == 112 && k == 1 && rxb === 1'b1, "bit time");
    $display("t_timing done");
  endtask : t_timing
  task automatic t_legacy;
    logic [31:0] q;
    msg(29'h0, 1, {HIGH_BUF, 5'h06}, "high f0");
    msg(29'h0, 1, {LOW_BUF, 5'h02}, "low f2");
    msg(29'h0, 0, '0, "both full");
    bus(0, OFS_STATUS, 0, q);
    chk(q[7:0] === 8'h03, "full flags");
    bus(0, OFS_HIT_LO, 0, q);
    chk(q[15:0] === 16'h0206, "hit codes");
    $display("t_legacy done");
  endtask : t_legacy
  task automatic t_mask;
    logic [31:0] q;
    bus(1, OFS_MASK0, 32'h1fffffff, q);
    bus(1, OFS_MASK1, 32'h1fffffff, q);
    bus(1, 8'h4c, 32'h5, q);
    bus(1, OFS_STATUS, 32'hff, q);
    msg(29'h4, 0, '0, "one bit off");
    msg(29'h5, 1, {LOW_BUF, 5'h03}, "f3 exact");
    bus(1, OFS_CTRL, 32'h0, q);
    bus(1, 8'h4c, 32'h4, q);
    bus(1, OFS_STATUS, 32'hff, q);
    msg(29'h5, 1, {LOW_BUF, 5'h03}, "filter kept");
    $display("t_mask done");
  endtask : t_mask
  // Rollover in legacy mode, then enhanced association, mask select and filter fifteen as mask
  task automatic t_enh;
    logic [31:0] q;
    int n;
    bus(1, OFS_CTRL, 32'h9, q);
    bus(1, OFS_STATUS, 32'hff, q);
    msg(29'h0, 1, {HIGH_BUF, 5'h06}, "roll high");
    msg(29'h0, 1, {LOW_BUF, 5'h00}, "roll low");
    bus(1, OFS_CTRL, 32'h13, q);
    bus(1, OFS_STATUS, 32'hff, q);
    bus(1, OFS_FEN, 32'h8005, q);
    bus(1, OFS_ASSOC_LO, 32'h403, q);
    bus(1, OFS_MSEL, 32'h20, q);
    msg(29'h0, 1, {4'h3, 5'h00}, "enh f0");
    msg(29'h9, 1, {4'h4, 5'h02}, "enh f2");
    msg(29'h9, 0, '0, "enh full");
    bus(0, OFS_HIT_HI, 0, q);
    chk(q[4:0] === 5'h02, "enh hit reg");
    // Wait for the node's closing recessive run to bring the bus back to idle
    n = 0;
    do
    begin
      bus(0, OFS_STATUS, 0, q);
      n++;
    end while (q[STAT_IDLE_BIT] !== 1'b1 && n < 1000);
    chk(q[STAT_IDLE_BIT] === 1'b1 && q[STAT_RUN6_BIT] === 1'b1, "six equal bits");
    $display("t_enh done");
  endtask : t_enh
  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Watchdog: the run needs well under 100 us
  initial
  begin
    #200000;
    errors++;
    results();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timing();
    t_legacy();
    t_mask();
    t_enh();
    results();
  end
endmodule : can_acceptance_filter_bit_timing_test
`default_nettype wire
